// ===== hdl/adc_link_defines.svh
/*
  Constants for the converter control and serial link: timing counts,
  command codes and reset values.
  Assumes a single 250 MHz core clock on each end.
*/
`ifndef ADC_LINK_DEFINES_SVH
`define ADC_LINK_DEFINES_SVH

`define CLK_NS           4
`define T_CONV_VOLT_NS   9000
`define T_CONV_TEMP_NS   27000
`define T_POWER_UP_NS    2000
`define T_CONV_PULSE_NS  20
`define T_SCLK_HALF_NS   64
// Cycles from a pin edge to its edge strobe behind the synchroniser
`define SYNC_CYC         5
// Longest times round down, least times round up
`define CONV_VOLT_CYC    (`T_CONV_VOLT_NS / `CLK_NS)
`define CONV_TEMP_CYC    (`T_CONV_TEMP_NS / `CLK_NS)
`define POWER_UP_CYC     (`T_POWER_UP_NS / `CLK_NS)
`define CONV_PULSE_CYC   ((`T_CONV_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define SCLK_HALF_CYC    ((`T_SCLK_HALF_NS + `CLK_NS - 1) / `CLK_NS)

`define RES_BITS         10
`define CNT_W            13
`define CHAN_TEMP        3'h0
`define CHAN_MAX         3'h4
`define CMD_LIMIT        8'h80
`define LIMIT_RST        8'hff
`define CHAN_RST         3'h0
`define RESULT_RST       10'h000
`define CHAN_BITS        5'h08
`define LIMIT_BITS       5'h10

`endif

// ===== hdl/adc_link_pkg.sv
/*
  Types shared by both ends of the converter link.
  Assumes adc_link_defines.svh for all numeric constants.
*/
package adc_link_pkg;
  typedef enum logic [3:0] {
    CV_IDLE  = 4'b0001,
    CV_CONV  = 4'b0010,
    CV_PDOWN = 4'b0100,
    CV_WAKE  = 4'b1000
  } conv_state_t;

  typedef enum logic [7:0] {
    H_IDLE = 8'b0000_0001,
    H_WAKE = 8'b0000_0010,
    H_CVLO = 8'b0000_0100,
    H_SEL  = 8'b0000_1000,
    H_RISE = 8'b0001_0000,
    H_LO   = 8'b0010_0000,
    H_HI   = 8'b0100_0000,
    H_DONE = 8'b1000_0000
  } host_state_t;

  typedef logic [9:0] result_t;
endpackage

// ===== hdl/adc_link_if.sv
/*
  Pin-level link between the converter and its host.
  Assumes the bench resolves the data output from its enable.
*/
`timescale 1ns/1ps
interface adc_link_if;
  logic convert_start_n;  // Start, falling edge
  logic busy;             // Conversion running
  logic over_temp_flag_n; // Over-temperature, low active
  logic cs_n;             // Chip select
  logic rd_wr;            // 1 read, 0 write
  logic sclk;             // Serial clock
  logic din;              // Host to device data
  logic dout;             // Device to host data
  logic dout_oe;          // Device drives dout

  modport dev  (input convert_start_n, cs_n, rd_wr, sclk, din,
                output busy, over_temp_flag_n, dout, dout_oe);
  modport host (output convert_start_n, cs_n, rd_wr, sclk, din,
                input busy, over_temp_flag_n, dout, dout_oe);
endinterface

// ===== hdl/adc_conv_dev.sv
/*
  Device end: conversion sequencing, power-down, over-temperature flag
  and serial port. The converter core is outside; its code arrives on
  CORE_CODE and is taken when a conversion ends.
  Assumes link pins are asynchronous to CORE_CLK.
*/
`timescale 1ns/1ps
`include "adc_link_defines.svh"
module adc_conv_dev #(
  parameter int unsigned TEMP_CONV_CYC = `CONV_TEMP_CYC
) (
  input  wire logic                 CORE_CLK,   // 250 MHz clock
  input  wire logic                 RST,        // Sync reset, high
  adc_link_if.dev                   LINK,       // Pins to host
  input  wire adc_link_pkg::result_t CORE_CODE, // Code from core
  output logic                      TRACK_HOLD, // 1 while holding
  output logic                      POWER_DOWN, // 1 while powered down
  output logic [2:0]                SEL_CHAN,   // Channel in use
  output adc_link_pkg::result_t     RESULT      // Last result
);
  import adc_link_pkg::*;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Bit order: 0 start, 1 select, 2 read/write, 3 sclk, 4 din
  logic [4:0] s1_q, s2_q, s3_q, filt_q, prev_q;
  logic [4:0] filt_d;

  always_comb begin
    // Change is accepted only once stages two and three agree
    filt_d = ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s1_q   <= 5'h1f;
      s2_q   <= 5'h1f;
      s3_q   <= 5'h1f;
      filt_q <= 5'h1f;
      prev_q <= 5'h1f;
    end else begin
      s1_q   <= {LINK.din, LINK.sclk, LINK.rd_wr, LINK.cs_n, LINK.convert_start_n};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end

  logic start_fall, start_rise, start_lvl;
  logic sel, cs_rise, rw_rise, rw_fall, sck_rise, sck_fall, din_lvl;

  assign start_lvl  = filt_q[0];
  assign start_fall = prev_q[0] & ~filt_q[0];
  assign start_rise = ~prev_q[0] & filt_q[0];
  assign sel        = ~filt_q[1];
  assign cs_rise    = ~prev_q[1] & filt_q[1];
  assign rw_rise    = ~prev_q[2] & filt_q[2];
  assign rw_fall    = prev_q[2] & ~filt_q[2];
  assign sck_rise   = ~prev_q[3] & filt_q[3];
  assign sck_fall   = prev_q[3] & ~filt_q[3];
  assign din_lvl    = filt_q[4];

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  conv_state_t        st_q, st_d;
  logic [`CNT_W-1:0]  cnt_q, cnt_d;
  logic               busy_q, busy_d, hold_q, hold_d, pd_q, pd_d;
  logic               oti_n_q, oti_n_d;
  logic [2:0]         cchan_q, cchan_d;
  result_t            res_q, res_d;
  logic               read_end;
  logic [2:0]         chan_q;
  logic [7:0]         limit_q;

  function automatic logic [`CNT_W-1:0] conv_len(input logic [2:0] ch);
    if (ch == `CHAN_TEMP)
      conv_len = `CNT_W'(TEMP_CONV_CYC - 1);
    else
      conv_len = `CNT_W'(`CONV_VOLT_CYC - 1);
  endfunction

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    busy_d  = busy_q;
    hold_d  = hold_q;
    pd_d    = pd_q;
    cchan_d = cchan_q;
    res_d   = res_q;
    oti_n_d = oti_n_q;
    if (read_end)
      oti_n_d = 1'b1;
    unique case (st_q)
      CV_IDLE: begin
        if (start_fall) begin
          st_d    = CV_CONV;
          cnt_d   = conv_len(chan_q);
          cchan_d = chan_q;
          busy_d  = 1'b1;
          hold_d  = 1'b1;
        end
      end
      CV_CONV: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - `CNT_W'(1);
        end else begin
          busy_d = 1'b0;
          hold_d = 1'b0;
          res_d  = CORE_CODE;
          // Set wins over a read ending in the same cycle
          if (cchan_q == `CHAN_TEMP && CORE_CODE[9:2] > limit_q)
            oti_n_d = 1'b0;
          if (!start_lvl) begin
            st_d = CV_PDOWN;
            pd_d = 1'b1;
          end else begin
            st_d = CV_IDLE;
          end
        end
      end
      CV_PDOWN: begin
        if (start_rise) begin
          st_d  = CV_WAKE;
          // Rise is seen late; count that off so wake ends in time
          cnt_d = `CNT_W'(`POWER_UP_CYC - 1 - `SYNC_CYC);
        end
      end
      CV_WAKE: begin
        // Start edges during wake-up are dropped: the core is not ready
        if (cnt_q != '0) begin
          cnt_d = cnt_q - `CNT_W'(1);
        end else begin
          st_d = CV_IDLE;
          pd_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_q    <= CV_IDLE;
      cnt_q   <= '0;
      busy_q  <= 1'b0;
      hold_q  <= 1'b0;
      pd_q    <= 1'b0;
      cchan_q <= `CHAN_RST;
      res_q   <= `RESULT_RST;
      oti_n_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      busy_q  <= busy_d;
      hold_q  <= hold_d;
      pd_q    <= pd_d;
      cchan_q <= cchan_d;
      res_q   <= res_d;
      oti_n_q <= oti_n_d;
    end
  end

  // ------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------
  logic [15:0] wsh_q, wsh_d;
  logic [4:0]  bits_q, bits_d;
  result_t     rsh_q, rsh_d;
  logic        dout_q, dout_d, oe_q, oe_d;
  logic [2:0]  chan_d;
  logic [7:0]  limit_d;
  logic        commit;

  assign read_end = sel & rw_rise;
  assign commit   = read_end | cs_rise;

  always_comb begin
    wsh_d   = wsh_q;
    bits_d  = bits_q;
    rsh_d   = rsh_q;
    dout_d  = dout_q;
    oe_d    = oe_q;
    chan_d  = chan_q;
    limit_d = limit_q;
    if (commit) begin
      if (bits_q == `CHAN_BITS && wsh_q[7:0] <= {5'h00, `CHAN_MAX})
        chan_d = wsh_q[2:0];
      if (bits_q == `LIMIT_BITS && wsh_q[15:8] == `CMD_LIMIT)
        limit_d = wsh_q[7:0];
      bits_d = '0;
    end
    if (cs_rise || (sel && rw_fall))
      oe_d = 1'b0;
    if (sel && rw_fall)
      bits_d = '0;
    if (read_end) begin
      rsh_d  = res_q;
      dout_d = res_q[9];
      oe_d   = 1'b1;
    end
    if (sel && !filt_q[2] && sck_rise) begin
      wsh_d = {wsh_q[14:0], din_lvl};
      if (bits_q != 5'h1f)
        bits_d = bits_q + 5'h01;
    end
    if (sel && filt_q[2] && oe_q && sck_fall) begin
      rsh_d  = {rsh_q[8:0], 1'b0};
      dout_d = rsh_q[8];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      wsh_q   <= 16'h0000;
      bits_q  <= 5'h00;
      rsh_q   <= `RESULT_RST;
      dout_q  <= 1'b0;
      oe_q    <= 1'b0;
      chan_q  <= `CHAN_RST;
      limit_q <= `LIMIT_RST;
    end else begin
      wsh_q   <= wsh_d;
      bits_q  <= bits_d;
      rsh_q   <= rsh_d;
      dout_q  <= dout_d;
      oe_q    <= oe_d;
      chan_q  <= chan_d;
      limit_q <= limit_d;
    end
  end

  assign LINK.busy             = busy_q;
  assign LINK.over_temp_flag_n = oti_n_q;
  assign LINK.dout             = dout_q;
  assign LINK.dout_oe          = oe_q;
  assign TRACK_HOLD            = hold_q;
  assign POWER_DOWN            = pd_q;
  assign SEL_CHAN              = chan_q;
  assign RESULT                = res_q;
endmodule

// ===== hdl/adc_host_ctrl.sv
/*
  Host end: pulses convert-start, writes control words and reads
  results over the serial port, making the serial clock by division.
  Assumes device outputs are asynchronous to CORE_CLK.
*/
`timescale 1ns/1ps
`include "adc_link_defines.svh"
module adc_host_ctrl (
  input  wire logic                 CORE_CLK,   // 250 MHz clock
  input  wire logic                 RST,        // Sync reset, high
  adc_link_if.host                  LINK,       // Pins to device
  input  wire logic                 CONV_REQ,   // Start a conversion
  input  wire logic                 STAY_AWAKE, // Leave start high after
  input  wire logic                 WR_REQ,     // Start a write
  input  wire logic                 WR_16,      // 1: 16 bits, 0: 8 bits
  input  wire logic [15:0]          WR_WORD,    // Write data, MSB first
  input  wire logic                 RD_REQ,     // Start a read
  output logic                      READY,      // Idle, takes requests
  output adc_link_pkg::result_t     RD_DATA,    // Read result
  output logic                      RD_DONE,    // Pulse: RD_DATA valid
  output logic                      BUSY_SEEN,  // Synced busy
  output logic                      OT_N_SEEN   // Synced flag
);
  import adc_link_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers: 0 busy, 1 flag, 2 dout
  // ------------------------------------------------------------
  logic [2:0] s1_q, s2_q, s3_q, filt_q, filt_d;

  always_comb begin
    filt_d = ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s1_q   <= 3'h2;
      s2_q   <= 3'h2;
      s3_q   <= 3'h2;
      filt_q <= 3'h2;
    end else begin
      s1_q   <= {LINK.dout, LINK.over_temp_flag_n, LINK.busy};
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  host_state_t       st_q, st_d;
  logic [`CNT_W-1:0] cnt_q, cnt_d;
  logic [4:0]        n_q, n_d;
  logic [15:0]       sh_q, sh_d;
  logic              rd_q, rd_d, cv_q, cv_d, cs_q, cs_d, rw_q, rw_d;
  logic              sck_q, sck_d, din_q, din_d, rdy_q, rdy_d, done_q, done_d;
  result_t           data_q, data_d;

  localparam logic [`CNT_W-1:0] HALF = `CNT_W'(`SCLK_HALF_CYC - 1);

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    n_d    = n_q;
    sh_d   = sh_q;
    rd_d   = rd_q;
    cv_d   = cv_q;
    cs_d   = cs_q;
    rw_d   = rw_q;
    sck_d  = sck_q;
    din_d  = din_q;
    data_d = data_q;
    done_d = 1'b0;
    rdy_d  = 1'b0;
    if (st_q != H_IDLE && cnt_q != '0) begin
      cnt_d = cnt_q - `CNT_W'(1);
    end else begin
      unique case (st_q)
        H_IDLE: begin
          rdy_d = 1'b1;
          if (CONV_REQ) begin
            st_d  = H_WAKE;
            rdy_d = 1'b0;
            // A low start line means power-down: allow power-up first
            cnt_d = cv_q ? '0 : `CNT_W'(`POWER_UP_CYC - 1);
            cv_d  = 1'b1;
          end else if (WR_REQ || RD_REQ) begin
            st_d  = H_SEL;
            rdy_d = 1'b0;
            rd_d  = ~WR_REQ;
            sh_d  = WR_16 ? WR_WORD : {WR_WORD[7:0], 8'h00};
            n_d   = WR_REQ ? (WR_16 ? 5'h10 : 5'h08) : 5'h0a;
            cs_d  = 1'b0;
            rw_d  = 1'b0;
            cnt_d = HALF;
          end
        end
        H_WAKE: begin
          st_d  = H_CVLO;
          cv_d  = 1'b0;
          cnt_d = `CNT_W'(`CONV_PULSE_CYC - 1);
        end
        H_CVLO: begin
          cv_d = STAY_AWAKE;
          st_d = H_IDLE;
        end
        H_SEL: begin
          cnt_d = HALF;
          if (rd_q) begin
            rw_d = 1'b1;
            st_d = H_RISE;
          end else begin
            sck_d = 1'b0;
            din_d = sh_q[15];
            sh_d  = {sh_q[14:0], 1'b0};
            st_d  = H_HI;
          end
        end
        H_RISE: begin
          // First bit stands before the first falling edge shifts it on
          data_d = {data_q[8:0], filt_q[2]};
          sck_d = 1'b0;
          st_d  = H_HI;
          cnt_d = HALF;
        end
        H_HI: begin
          sck_d = 1'b1;
          st_d  = H_LO;
          cnt_d = HALF;
          n_d   = n_q - 5'h01;
        end
        H_LO: begin
          cnt_d = HALF;
          // Last fall only shifts a zero out, nothing to take
          if (rd_q && n_q != 5'h00)
            data_d = {data_q[8:0], filt_q[2]};
          if (n_q == 5'h00) begin
            cs_d = 1'b1;
            st_d = H_DONE;
          end else begin
            sck_d = 1'b0;
            if (!rd_q) begin
              din_d = sh_q[15];
              sh_d  = {sh_q[14:0], 1'b0};
            end
            st_d = H_HI;
          end
        end
        H_DONE: begin
          rw_d   = 1'b1;
          done_d = rd_q;
          st_d   = H_IDLE;
        end
        default: st_d = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_q   <= H_IDLE;
      cnt_q  <= '0;
      n_q    <= 5'h00;
      sh_q   <= 16'h0000;
      rd_q   <= 1'b0;
      cv_q   <= 1'b1;
      cs_q   <= 1'b1;
      rw_q   <= 1'b1;
      sck_q  <= 1'b1;
      din_q  <= 1'b0;
      rdy_q  <= 1'b0;
      done_q <= 1'b0;
      data_q <= `RESULT_RST;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      n_q    <= n_d;
      sh_q   <= sh_d;
      rd_q   <= rd_d;
      cv_q   <= cv_d;
      cs_q   <= cs_d;
      rw_q   <= rw_d;
      sck_q  <= sck_d;
      din_q  <= din_d;
      rdy_q  <= rdy_d;
      done_q <= done_d;
      data_q <= data_d;
    end
  end

  assign LINK.convert_start_n = cv_q;
  assign LINK.cs_n            = cs_q;
  assign LINK.rd_wr           = rw_q;
  assign LINK.sclk            = sck_q;
  assign LINK.din             = din_q;
  assign READY                = rdy_q;
  assign RD_DATA              = data_q;
  assign RD_DONE              = done_q;
  assign BUSY_SEEN            = filt_q[0];
  assign OT_N_SEEN            = filt_q[1];
endmodule

// ===== bench/adc_link_chk.sv
/*
  Checker for the converter link pins: busy timing, flag set and release,
  data output enable and shift timing.
  Assumes tb instantiates it beside the link interface, with no bind.
*/
`timescale 1ns/1ps
`include "adc_link_defines.svh"
module adc_link_chk #(
  parameter int unsigned TEMP_CONV_CYC = `CONV_TEMP_CYC
) (
  input wire logic CORE_CLK,         // Core clock
  input wire logic RST,              // Sync reset, high
  input wire logic convert_start_n,  // Start pin
  input wire logic busy,             // Busy pin
  input wire logic over_temp_flag_n, // Flag pin
  input wire logic cs_n,             // Select pin
  input wire logic rd_wr,            // Direction pin
  input wire logic sclk,             // Serial clock
  input wire logic dout,             // Device data
  input wire logic dout_oe           // Device drives dout
);
  logic [`CNT_W-1:0] busy_cnt_q;
  logic [`CNT_W-1:0] busy_cnt_d;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // Busy length counter; reads its final count on the busy fall
  always_comb begin
    busy_cnt_d = busy ? busy_cnt_q + `CNT_W'(1) : `CNT_W'(0);
  end
  always_ff @(posedge CORE_CLK) begin
    busy_cnt_q <= RST ? `CNT_W'(0) : busy_cnt_d;
  end

  a_busy_len: assert property (
    $fell(busy) |-> busy_cnt_q == `CNT_W'(`CONV_VOLT_CYC) ||
                    busy_cnt_q == `CNT_W'(TEMP_CONV_CYC))
    else $error("busy length wrong");
  a_busy_on_start: assert property (
    $fell(convert_start_n) && !busy |-> ##[1:12] busy)
    else $error("busy late after start fall");
  a_busy_holds: assert property (
    $rose(busy) |-> busy [*8])
    else $error("busy pulse too short");
  a_flag_at_end: assert property (
    $fell(over_temp_flag_n) |-> $fell(busy))
    else $error("flag set outside conversion end");
  a_flag_release: assert property (
    !over_temp_flag_n && !cs_n && $rose(rd_wr) |-> ##[1:12] over_temp_flag_n)
    else $error("flag not released by read");
  a_oe_needs_read: assert property (
    $rose(dout_oe) |-> !cs_n && rd_wr)
    else $error("dout driven without read select");
  a_oe_on_read: assert property (
    !cs_n && $rose(rd_wr) |-> ##[1:8] dout_oe)
    else $error("dout not driven after read start");
  a_float_on_rw: assert property (
    $fell(rd_wr) && !cs_n |-> ##[1:8] !dout_oe)
    else $error("dout not released on direction fall");
  a_float_on_cs: assert property (
    $rose(cs_n) |-> ##[1:8] !dout_oe)
    else $error("dout not released on deselect");
  a_dout_steady: assert property (
    dout_oe && $past(dout_oe) && sclk && $past(sclk) |-> $stable(dout))
    else $error("dout moved while sclk high");
endmodule

// ===== bench/tb.sv
/*
  Testbench: host end and device end joined by one link, plus a second
  device driven by raw pin tasks for deselect and release checks.
  Assumes the design sources and the link checker are compiled first.
*/
`timescale 1ns/1ps
module tb;
  import adc_link_pkg::*;
  localparam int unsigned TCONV = 40;
  logic        CORE_CLK, RST, CONV_REQ, STAY_AWAKE, WR_REQ, WR_16, RD_REQ;
  logic [15:0] WR_WORD;
  result_t     core_code, rd_data, result;
  logic        track_hold, power_down, ready, rd_done, busy_seen, ot_seen;
  logic [2:0]  sel_chan, sel_chan_b;
  int          err_total, samples_checked, pu_cnt, pu_last;

  adc_link_if link ();
  adc_link_if link_b ();
  adc_conv_dev #(.TEMP_CONV_CYC(TCONV)) adc_conv_dev_inst (.CORE_CLK(CORE_CLK), .RST(RST),
    .LINK(link), .CORE_CODE(core_code), .TRACK_HOLD(track_hold), .POWER_DOWN(power_down),
    .SEL_CHAN(sel_chan), .RESULT(result));
  adc_conv_dev #(.TEMP_CONV_CYC(TCONV)) adc_conv_dev_inst_b (.CORE_CLK(CORE_CLK), .RST(RST),
    .LINK(link_b), .CORE_CODE(core_code), .TRACK_HOLD(), .POWER_DOWN(),
    .SEL_CHAN(sel_chan_b), .RESULT());
  adc_host_ctrl adc_host_ctrl_inst (.CORE_CLK(CORE_CLK), .RST(RST), .LINK(link),
    .CONV_REQ(CONV_REQ), .STAY_AWAKE(STAY_AWAKE), .WR_REQ(WR_REQ), .WR_16(WR_16),
    .WR_WORD(WR_WORD), .RD_REQ(RD_REQ), .READY(ready), .RD_DATA(rd_data),
    .RD_DONE(rd_done), .BUSY_SEEN(busy_seen), .OT_N_SEEN(ot_seen));
  adc_link_chk #(.TEMP_CONV_CYC(TCONV)) adc_link_chk_inst (.CORE_CLK(CORE_CLK), .RST(RST),
    .convert_start_n(link.convert_start_n), .busy(link.busy),
    .over_temp_flag_n(link.over_temp_flag_n), .cs_n(link.cs_n), .rd_wr(link.rd_wr),
    .sclk(link.sclk), .dout(link.dout), .dout_oe(link.dout_oe));

  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  // Wake time: cycles powered down while the start pin is already high
  always @(posedge CORE_CLK) begin
    if (power_down === 1'b1 && link.convert_start_n === 1'b1) begin
      pu_cnt <= pu_cnt + 1;
    end else if (pu_cnt != 0) begin
      pu_last <= pu_cnt;
      pu_cnt  <= 0;
    end
  end

  // ----------------------------------------
  // Compare, report and access tasks
  // ----------------------------------------
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_vec(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick;
    @(posedge CORE_CLK);
    #1;
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 5000) begin
      tick;
      n++;
    end
    cmp_bit("ready", 1'b1, ready);
  endtask

  task automatic host_op(input logic c, w, r, w16, input logic [15:0] word);
    wait_ready;
    {CONV_REQ, WR_REQ, RD_REQ, WR_16, WR_WORD} = {c, w, r, w16, word};
    tick;
    {CONV_REQ, WR_REQ, RD_REQ} = 3'h0;
    tick;
  endtask

  task automatic wr(input logic w16, input logic [15:0] word);
    host_op(1'b0, 1'b1, 1'b0, w16, word);
    wait_ready;
    repeat (12) tick;
  endtask

  task automatic rd(input result_t exp);
    int n;
    host_op(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
    n = 0;
    while (rd_done !== 1'b1 && n < 2000) begin
      tick;
      n++;
    end
    cmp_vec("read data", 16'(exp), 16'(rd_data));
  endtask

  task automatic convert(input logic awake, input result_t code, output int len);
    int n;
    STAY_AWAKE = awake;
    core_code  = code;
    host_op(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
    n   = 0;
    len = 0;
    while (link.busy !== 1'b1 && n < 700) begin
      tick;
      n++;
    end
    cmp_bit("hold", 1'b1, track_hold);
    while (link.busy === 1'b1 && len < 9000) begin
      tick;
      len++;
    end
    cmp_bit("track", 1'b0, track_hold);
    cmp_vec("result", 16'(code), 16'(result));
    cmp_bit("power down", ~awake, power_down);
  endtask

  // Raw pins of the second device; half period 62.5 ns, off the core phase
  task automatic raw(input logic cs, input logic rd, input logic [7:0] b);
    link_b.cs_n  = cs;
    link_b.rd_wr = 1'b0;
    #62.5;
    if (rd) begin
      link_b.rd_wr = 1'b1;
      #62.5;
      cmp_bit("drive", ~cs, link_b.dout_oe);
    end
    for (int i = 7; i >= 0; i--) begin
      link_b.sclk = 1'b0;
      link_b.din  = b[i];
      #62.5;
      link_b.sclk = 1'b1;
      #62.5;
    end
    if (rd) begin
      link_b.rd_wr = 1'b0;
      #62.5;
      cmp_bit("float", 1'b0, link_b.dout_oe);
    end
    link_b.cs_n = 1'b1;
    #250;
  endtask

  // ----------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------
  initial begin
    #200000;
    err_total++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    report_and_stop;
  end

  initial begin
    int len;
    result_t codes [3];
    codes = '{10'h103, 10'h104, 10'h3ff};
    {RST, CONV_REQ, WR_REQ, RD_REQ, WR_16, STAY_AWAKE} = 6'h20;
    WR_WORD   = 16'h0000;
    core_code = 10'h000;
    {link_b.convert_start_n, link_b.cs_n, link_b.rd_wr, link_b.sclk, link_b.din} = 5'h1e;
    repeat (12) tick;
    RST = 1'b0;
    repeat (8) tick;
    cmp_bit("busy", 1'b0, link.busy);
    cmp_bit("flag", 1'b1, link.over_temp_flag_n);
    cmp_bit("oe", 1'b0, link.dout_oe);
    cmp_bit("power down", 1'b0, power_down);
    cmp_vec("chan", 16'h0000, 16'(sel_chan));
    $display("test reset done");
    for (int ch = 1; ch <= 4; ch++) begin
      wr(1'b0, 16'(ch));
      cmp_vec("chan", 16'(ch), 16'(sel_chan));
      convert(1'b1, 10'(ch * 32'h0000_00c9), len);
      cmp_vec("conv len", 16'h08ca, 16'(len));
      rd(10'(ch * 32'h0000_00c9));
    end
    wr(1'b0, 16'h0005);
    cmp_vec("chan", 16'h0004, 16'(sel_chan));
    $display("test voltage done");
    wr(1'b1, 16'h8040);
    wr(1'b1, 16'h7fff);
    wr(1'b0, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      convert(1'b0, codes[i], len);
      cmp_vec("temp len", 16'(TCONV), 16'(len));
      cmp_bit("flag", !(codes[i][9:2] > 8'h40), link.over_temp_flag_n);
      if (i > 0)
        cmp_bit("wake", 1'b1, pu_last > 0 && pu_last <= 508);
      repeat (8) tick;
      cmp_bit("flag seen", !(codes[i][9:2] > 8'h40), ot_seen);
      cmp_bit("busy seen", 1'b0, busy_seen);
      rd(codes[i]);
      cmp_bit("flag clear", 1'b1, link.over_temp_flag_n);
    end
    $display("test temperature done");
    raw(1'b1, 1'b0, 8'h02);
    cmp_vec("chan b", 16'h0000, 16'(sel_chan_b));
    raw(1'b0, 1'b0, 8'h02);
    cmp_vec("chan b", 16'h0002, 16'(sel_chan_b));
    raw(1'b1, 1'b1, 8'h00);
    raw(1'b0, 1'b1, 8'h00);
    $display("test select done");
    tick;
    report_and_stop;
  end
endmodule
